/* File: dscr_params.svh */
// Purpose: offsets, field positions, reset values and timing figures of the clamp/status bank
// Assumes: 200 MHz system clock, byte-wide registers at their subaddresses
// Notes: included by the design modules dscr_rst_seq and dscr_regs, not by the package
// How it works
// [RL1] status_two bit0 shows colour striping present
// [RL2] status_two bit1 gives striping variant, 1=third
// [RL3] status_two bits2-3 show copy guard, bits4-5 nonstandard line length, subcarrier
// [RL4] status_three shows lock, free-run, field, burst
// [RL5] analog clamp bit4 switches current sources
// [RL6] host keeps analog clamp reserved bits default
// [RL7] fine_clamp_speed picks one, half, tenth second
// [RL8] speed 11 follows video-derived time constant
// [RL9] soft_reset_bit reloads defaults, self clears, 2 ms
// [RL10] status writes ignored, reads change nothing
// [RL11] host keeps digital clamp reserved bits default
`ifndef DSCR_PARAMS_SVH
`define DSCR_PARAMS_SVH

// subaddresses
`define DSCR_ADDR_POWER 8'h0f
`define DSCR_ADDR_STATUS_TWO 8'h12
`define DSCR_ADDR_STATUS_THREE 8'h13
`define DSCR_ADDR_ANALOG_CLAMP 8'h14
`define DSCR_ADDR_DIGITAL_CLAMP 8'h15

// field positions
`define DSCR_SOFT_RESET_BIT 7
`define DSCR_CURRENT_CLAMP_ON_BIT 4
`define DSCR_FINE_SPEED_LSB 5

// reset values
`define DSCR_ANALOG_CLAMP_RST 8'h12
`define DSCR_DIGITAL_CLAMP_RST 8'h00

// timing figures and derived cycle counts
`define DSCR_CLK_MHZ 200
`define DSCR_SOFT_RESET_US 2000
`define DSCR_SOFT_RESET_CYC (`DSCR_SOFT_RESET_US * `DSCR_CLK_MHZ)
`define DSCR_TC_SLOW_MS 1000
`define DSCR_TC_MEDIUM_MS 500
`define DSCR_TC_FAST_MS 100
`define DSCR_TC_SLOW_CYC (`DSCR_TC_SLOW_MS * `DSCR_CLK_MHZ * 1000)
`define DSCR_TC_MEDIUM_CYC (`DSCR_TC_MEDIUM_MS * `DSCR_CLK_MHZ * 1000)
`define DSCR_TC_FAST_CYC (`DSCR_TC_FAST_MS * `DSCR_CLK_MHZ * 1000)

`endif

/* File: dscr_pkg.sv */
// Purpose: types shared by the clamp/status register bank
// Assumes: byte-wide registers
// Notes: numbers live in dscr_params.svh
package dscr_pkg;

	// fine clamp time constant choices
	typedef enum logic [1:0] {
		DSCR_TC_SLOW = 2'b00,
		DSCR_TC_MEDIUM = 2'b01,
		DSCR_TC_FAST = 2'b10,
		DSCR_TC_ADAPT = 2'b11
	} dscr_speed_t;

	// live flags feeding status_two
	typedef struct packed {
		logic nonstd_subcarrier;
		logic nonstd_line_length;
		logic copy_guard_agc;
		logic copy_guard_pseudosync;
		logic stripe_type_three;
		logic stripe_detected;
	} dscr_status_two_t;

	// live flags feeding status_three
	typedef struct packed {
		logic swinging_burst;
		logic field_len_std;
		logic free_run;
		logic hlock_raw;
	} dscr_status_three_t;

	// register access request
	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dscr_req_t;

endpackage : dscr_pkg

/* File: dscr_rst_seq.sv */
// Purpose: soft reset sequencer, holds busy for the reset duration
// Assumes: start is a one-cycle pulse
// Notes: duration is a parameter so simulation may shorten it
`timescale 1ns/10ps
`include "dscr_params.svh"
module dscr_rst_seq import dscr_pkg::*; #(
	parameter int unsigned CYCLES = `DSCR_SOFT_RESET_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// control
	input wire logic i_start,
	output logic o_busy_ff,
	output logic o_load_ff
);

	// the countdown needs at least two cycles of busy
	if (CYCLES < 2) begin : g_bad_cycles
		$error("dscr_rst_seq: CYCLES must be at least 2");
	end

	logic [31:0] cnt_ff;

	// countdown while busy, load pulse at start
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			cnt_ff <= 32'h0000_0000;
			o_busy_ff <= 1'b0;
			o_load_ff <= 1'b0;
		end else begin
			o_load_ff <= i_start && !o_busy_ff; // [RL9]
			if (i_start && !o_busy_ff) begin
				cnt_ff <= 32'(CYCLES - 1);
				o_busy_ff <= 1'b1; // [RL9]
			end else if (o_busy_ff) begin
				if (cnt_ff == 32'h0000_0000) begin
					o_busy_ff <= 1'b0; // self clearing [RL9]
				end else begin
					cnt_ff <= cnt_ff - 32'h0000_0001;
				end
			end
		end
	end

endmodule : dscr_rst_seq

/* File: dscr_regs.sv */
// Purpose: status and clamp control registers of the video decoder
// Assumes: access port is the parallel side of the two-wire serial interface
// Notes: status flags come from decoder logic on the same clock
`timescale 1ns/10ps
`include "dscr_params.svh"
module dscr_regs import dscr_pkg::*; #(
	parameter int unsigned RESET_CYCLES = `DSCR_SOFT_RESET_CYC,
	parameter int unsigned TC_SLOW_CYCLES = `DSCR_TC_SLOW_CYC,
	parameter int unsigned TC_MEDIUM_CYCLES = `DSCR_TC_MEDIUM_CYC,
	parameter int unsigned TC_FAST_CYCLES = `DSCR_TC_FAST_CYC
) (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// register access
	input wire dscr_req_t i_req,
	output logic [7:0] o_rdata_ff,
	output logic o_ack_ff,
	// live decoder flags and video-derived period
	input wire dscr_status_two_t i_status_two,
	input wire dscr_status_three_t i_status_three,
	input wire logic [31:0] i_adapt_tc_cycles,
	// clamp controls and soft reset busy flag
	output logic o_current_clamp_on_ff,
	output dscr_speed_t o_fine_clamp_speed_ff,
	output logic o_fine_clamp_tick_ff,
	output logic o_soft_reset_busy_ff
);

	////////////////////////////////////////////////////////////////////////////////
	// parameter checks

	// the tick counter needs a period of two cycles or more
	if (TC_SLOW_CYCLES < 2) begin : g_bad_slow
		$error("dscr_regs: TC_SLOW_CYCLES must be at least 2");
	end
	if (TC_MEDIUM_CYCLES < 2) begin : g_bad_medium
		$error("dscr_regs: TC_MEDIUM_CYCLES must be at least 2");
	end
	if (TC_FAST_CYCLES < 2) begin : g_bad_fast
		$error("dscr_regs: TC_FAST_CYCLES must be at least 2");
	end
	// the sequencer needs a busy span of two cycles or more
	if (RESET_CYCLES < 2) begin : g_bad_reset
		$error("dscr_regs: RESET_CYCLES must be at least 2");
	end

	////////////////////////////////////////////////////////////////////////////////
	// soft reset

	logic soft_start;
	logic busy;
	logic load;

	// write of soft_reset_bit starts the sequence
	assign soft_start = i_req.wr && (i_req.addr == `DSCR_ADDR_POWER)
		&& i_req.wdata[`DSCR_SOFT_RESET_BIT]; // [RL9]

	dscr_rst_seq #(
		.CYCLES(RESET_CYCLES)
	) u_rst_seq (
		.i_clk(i_clk),
		.i_nrst(i_nrst),
		.i_start(soft_start),
		.o_busy_ff(busy),
		.o_load_ff(load)
	);

	// busy flag to the port, one cycle late
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_soft_reset_busy_ff <= 1'b0;
		end else begin
			o_soft_reset_busy_ff <= busy;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// writable registers

	logic [7:0] analog_clamp_control_ff;
	logic [7:0] digital_clamp_control_ff;
	logic wr_ok;

	// writes are dropped while the reset sequence runs
	assign wr_ok = i_req.wr && !busy;

	// analog clamp control, whole byte stored, host keeps reserved bits [RL6]
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			analog_clamp_control_ff <= `DSCR_ANALOG_CLAMP_RST;
		end else if (load) begin
			analog_clamp_control_ff <= `DSCR_ANALOG_CLAMP_RST; // [RL9]
		end else if (wr_ok && i_req.addr == `DSCR_ADDR_ANALOG_CLAMP) begin
			analog_clamp_control_ff <= i_req.wdata;
		end
	end

	// digital clamp control, host keeps reserved bits [RL11]
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			digital_clamp_control_ff <= `DSCR_DIGITAL_CLAMP_RST;
		end else if (load) begin
			digital_clamp_control_ff <= `DSCR_DIGITAL_CLAMP_RST; // [RL9]
		end else if (wr_ok && i_req.addr == `DSCR_ADDR_DIGITAL_CLAMP) begin
			digital_clamp_control_ff <= i_req.wdata;
		end
	end

	// current source gate to the front end
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_current_clamp_on_ff <= 1'b0;
		end else begin
			o_current_clamp_on_ff <= analog_clamp_control_ff[`DSCR_CURRENT_CLAMP_ON_BIT]; // [RL5]
		end
	end

	// fine clamp speed to the front end
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_fine_clamp_speed_ff <= DSCR_TC_SLOW;
		end else begin
			o_fine_clamp_speed_ff <= dscr_speed_t'(
				digital_clamp_control_ff[`DSCR_FINE_SPEED_LSB +: 2]); // [RL7]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// fine clamp time constant tick

	logic [31:0] tc_period;
	logic [31:0] tc_cnt_ff;

	// period from the selected speed
	always_comb begin
		unique case (o_fine_clamp_speed_ff)
			DSCR_TC_SLOW: tc_period = 32'(TC_SLOW_CYCLES); // [RL7]
			DSCR_TC_MEDIUM: tc_period = 32'(TC_MEDIUM_CYCLES); // [RL7]
			DSCR_TC_FAST: tc_period = 32'(TC_FAST_CYCLES); // [RL7]
			DSCR_TC_ADAPT: begin
				// video-derived, never below two cycles
				if (i_adapt_tc_cycles < 32'h0000_0002) begin
					tc_period = 32'h0000_0002; // [RL8]
				end else begin
					tc_period = i_adapt_tc_cycles; // [RL8]
				end
			end
		endcase
	end

	// one pulse per time constant
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			tc_cnt_ff <= 32'h0000_0000;
			o_fine_clamp_tick_ff <= 1'b0;
		end else if (tc_cnt_ff >= tc_period - 32'h0000_0001) begin
			tc_cnt_ff <= 32'h0000_0000;
			o_fine_clamp_tick_ff <= 1'b1;
		end else begin
			tc_cnt_ff <= tc_cnt_ff + 32'h0000_0001;
			o_fine_clamp_tick_ff <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// status capture, read only

	logic [7:0] status_two_ff;
	logic [7:0] status_three_ff;

	// status_two follows the decoder live, no write path reaches it
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			status_two_ff <= 8'h00;
		end else begin
			status_two_ff <= {2'b00, i_status_two}; // [RL1] [RL2] [RL3] [RL10]
		end
	end

	// status_three follows the decoder live, unused bits read zero
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			status_three_ff <= 8'h00;
		end else begin
			status_three_ff <= {i_status_three.swinging_burst,
				i_status_three.field_len_std,
				i_status_three.free_run,
				3'b000,
				i_status_three.hlock_raw,
				1'b0}; // [RL4] [RL10]
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// read data and acknowledge

	logic [7:0] nxt_rdata;

	// read mux, unmapped reads as zero
	always_comb begin
		unique case (i_req.addr)
			`DSCR_ADDR_POWER: nxt_rdata = {busy, 7'h00}; // [RL9]
			`DSCR_ADDR_STATUS_TWO: nxt_rdata = status_two_ff; // [RL10]
			`DSCR_ADDR_STATUS_THREE: nxt_rdata = status_three_ff; // [RL10]
			`DSCR_ADDR_ANALOG_CLAMP: nxt_rdata = analog_clamp_control_ff;
			`DSCR_ADDR_DIGITAL_CLAMP: nxt_rdata = digital_clamp_control_ff;
			default: nxt_rdata = 8'h00;
		endcase
	end

	// acknowledge one cycle after any access, refused writes too
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_ack_ff <= 1'b0;
		end else begin
			o_ack_ff <= i_req.rd || i_req.wr;
		end
	end

	// read data, held until the next read
	always_ff @(posedge i_clk or negedge i_nrst) begin
		if (!i_nrst) begin
			o_rdata_ff <= 8'h00;
		end else if (i_req.rd) begin
			o_rdata_ff <= nxt_rdata; // [RL10]
		end
	end

endmodule : dscr_regs

/* File: dscr_regs_monitor.sv */
// Purpose: port checks of the clamp/status bank
// Assumes: one clock domain
// Notes: bound to dscr_regs below
`timescale 1ns/10ps
module dscr_regs_monitor import dscr_pkg::*; (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_nrst,
	// watched ports
	input wire dscr_req_t i_req,
	input wire dscr_status_two_t i_status_two,
	input wire dscr_status_three_t i_status_three,
	input wire logic [7:0] o_rdata_ff,
	input wire logic o_ack_ff,
	input wire logic o_current_clamp_on_ff,
	input wire dscr_speed_t o_fine_clamp_speed_ff,
	input wire logic o_soft_reset_busy_ff
);
	logic [7:0] st3_img;
	// status_three bit layout
	assign st3_img = {i_status_three[3:1], 3'h0, i_status_three[0], 1'h0};
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	////////////////////////////////
	// read taken, write taken outside soft reset
	sequence s_rd(a); i_req.rd && i_req.addr == a; endsequence
	sequence s_wr(a); i_req.wr && i_req.addr == a ##1 !o_soft_reset_busy_ff; endsequence
	a_ack_after_req: assert property ((i_req.rd || i_req.wr) |=> o_ack_ff)
		else $error("ack missing");
	a_ack_has_cause: assert property (o_ack_ff |-> $past(i_req.rd || i_req.wr))
		else $error("ack without request");
	a_rd_status_two: assert property (s_rd(8'h12)
		|=> o_rdata_ff == {2'h0, $past(i_status_two, 2)}) else $error("status two read wrong");
	a_rd_status_three: assert property (s_rd(8'h13) |=> o_rdata_ff == $past(st3_img, 2))
		else $error("status three read wrong");
	a_rd_unmapped_zero: assert property (i_req.rd
		&& !(i_req.addr inside {8'h0f, [8'h12:8'h15]}) |=> o_rdata_ff == 8'h00)
		else $error("unmapped read not zero");
	a_clamp_follows_write: assert property (s_wr(8'h14)
		|=> o_current_clamp_on_ff == $past(i_req.wdata[4], 2)) else $error("clamp enable wrong");
	a_speed_follows_write: assert property (s_wr(8'h15)
		|=> o_fine_clamp_speed_ff == $past(i_req.wdata[6:5], 2)) else $error("clamp speed wrong");
	a_busy_starts: assert property (i_req.wr && i_req.addr == 8'h0f
		&& i_req.wdata[7] |-> ##[1:3] o_soft_reset_busy_ff) else $error("soft reset not busy");
endmodule : dscr_regs_monitor
bind dscr_regs dscr_regs_monitor i_dscr_regs_monitor (.i_clk, .i_nrst, .i_req, .i_status_two,
	.i_status_three, .o_rdata_ff, .o_ack_ff, .o_current_clamp_on_ff, .o_fine_clamp_speed_ff,
	.o_soft_reset_busy_ff);

/* File: dscr_host.sv */
// Purpose: host side of the register port
// Assumes: one request at a time
// Notes: keeps reserved clamp bits at default
`timescale 1ns/10ps
module dscr_host import dscr_pkg::*; (
	// clock
	input wire logic i_clk,
	// answer
	input wire logic i_ack,
	input wire logic [7:0] i_rdata,
	// request
	output dscr_req_t o_req
);
	// idle at time zero
	initial o_req = '0;
	////////////////////////////////
	// one-cycle request, then bounded wait for ack
	task automatic access(input logic w, input logic [7:0] a, d, output logic [7:0] q);
		int n;
		@(posedge i_clk);
		o_req <= '{w, !w, a, d};
		@(posedge i_clk);
		o_req <= '0;
		#1;
		for (n = 0; n < 4 && i_ack !== 1'b1; n++) begin
			@(posedge i_clk);
			#1;
		end
		q = i_rdata;
	endtask : access
	// clamp writes with reserved bits at default
	task automatic set_clamp(input logic on);
		logic [7:0] q;
		access(1'b1, 8'h14, {3'h0, on, 4'h2}, q);
	endtask : set_clamp
	task automatic set_speed(input logic [1:0] s);
		logic [7:0] q;
		access(1'b1, 8'h15, {1'b0, s, 5'h0}, q);
	endtask : set_speed
endmodule : dscr_host

/* File: tb.sv */
// Purpose: self-checking bench of the clamp/status bank
// Assumes: short soft reset and clamp periods
// Notes: host model issues all requests
`timescale 1ns/10ps
module tb import dscr_pkg::*;;
	// design ports and bench state
	logic i_clk = 1'b0;
	logic i_nrst = 1'b0;
	dscr_req_t i_req;
	dscr_status_two_t i_status_two = '0;
	dscr_status_three_t i_status_three = '0;
	logic [31:0] i_adapt_tc_cycles = 32'h5;
	logic [7:0] o_rdata_ff, q;
	logic o_ack_ff, o_current_clamp_on_ff, o_fine_clamp_tick_ff, o_soft_reset_busy_ff;
	dscr_speed_t o_fine_clamp_speed_ff;
	int failures = 0;
	int samples_checked = 0;
	int n, g;
	logic [7:0] per[4] = '{8'h28, 8'h14, 8'h08, 8'h05};
	logic [7:0] s3map[4] = '{8'h02, 8'h20, 8'h40, 8'h80};
	// 200 MHz clock
	always #2.5 i_clk = ~i_clk;
	////////////////////////////////
	dscr_regs #(.RESET_CYCLES(8), .TC_SLOW_CYCLES(40), .TC_MEDIUM_CYCLES(20),
		.TC_FAST_CYCLES(8)) i_dscr_regs (.i_clk, .i_nrst, .i_req, .o_rdata_ff, .o_ack_ff,
		.i_status_two, .i_status_three, .i_adapt_tc_cycles, .o_current_clamp_on_ff,
		.o_fine_clamp_speed_ff, .o_fine_clamp_tick_ff, .o_soft_reset_busy_ff);
	dscr_host i_dscr_host (.i_clk, .i_ack(o_ack_ff), .i_rdata(o_rdata_ff), .o_req(i_req));
	// compare and count
	task automatic chk(input string what, input logic [7:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// read and compare
	task automatic rdc(input string what, input logic [7:0] a, exp);
		i_dscr_host.access(1'b0, a, 8'h00, q);
		chk(what, exp, q);
	endtask : rdc
	// cycles to the next clamp tick
	task automatic gap(output int p);
		p = 0;
		do begin
			@(posedge i_clk);
			#1;
			p++;
		end while (o_fine_clamp_tick_ff !== 1'b1 && p < 100);
	endtask : gap
	// verdict and end of run
	task automatic summarize;
		$display("checked %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : summarize
	// watchdog
	initial begin
		#30000;
		failures++;
		summarize();
	end
	// test sequence
	initial begin
		repeat (3) @(posedge i_clk);
		i_nrst <= 1'b1;
		@(posedge i_clk);
		#1;
		chk("clamp on", 8'h01, {7'h0, o_current_clamp_on_ff});
		rdc("analog clamp", 8'h14, 8'h12);
		rdc("digital clamp", 8'h15, 8'h00);
		for (n = 0; n < 6; n++) begin
			@(posedge i_clk);
			i_status_two <= 6'h01 << n;
			i_status_three <= 4'h1 << (n % 4);
			rdc("status two", 8'h12, 8'h01 << n);
			rdc("status three", 8'h13, s3map[n % 4]);
		end
		i_dscr_host.access(1'b1, 8'h12, 8'hff, q);
		i_dscr_host.access(1'b1, 8'h13, 8'h00, q);
		rdc("status two", 8'h12, 8'h20);
		rdc("status three", 8'h13, 8'h20);
		rdc("unmapped", 8'h20, 8'h00);
		for (n = 0; n < 2; n++) begin
			i_dscr_host.set_clamp(n[0]);
			@(posedge i_clk);
			#1;
			chk("clamp on", n[0], {7'h0, o_current_clamp_on_ff});
			rdc("analog clamp", 8'h14, {3'h0, n[0], 4'h2});
		end
		for (n = 0; n < 4; n++) begin
			i_dscr_host.set_speed(n[1:0]);
			@(posedge i_clk);
			#1;
			chk("speed", n[1:0], {6'h0, o_fine_clamp_speed_ff});
			gap(g);
			gap(g);
			gap(g);
			chk("tick period", per[n], g[7:0]);
		end
		// video-derived period below two is held at two
		@(posedge i_clk);
		i_adapt_tc_cycles <= 32'h0000_0001;
		gap(g);
		gap(g);
		gap(g);
		chk("tick period", 8'h02, g[7:0]);
		i_dscr_host.set_clamp(1'b0);
		i_dscr_host.access(1'b1, 8'h0f, 8'h80, q);
		i_dscr_host.set_speed(2'h2);
		chk("busy", 8'h01, {7'h0, o_soft_reset_busy_ff});
		rdc("soft reset bit", 8'h0f, 8'h80);
		repeat (12) @(posedge i_clk);
		rdc("analog clamp", 8'h14, 8'h12);
		rdc("digital clamp", 8'h15, 8'h00);
		rdc("soft reset bit", 8'h0f, 8'h00);
		// hard reset in mid-run brings the defaults back
		i_dscr_host.set_clamp(1'b0);
		i_dscr_host.set_speed(2'h1);
		@(posedge i_clk);
		i_nrst <= 1'b0;
		repeat (3) @(posedge i_clk);
		i_nrst <= 1'b1;
		@(posedge i_clk);
		#1;
		chk("clamp on", 8'h01, {7'h0, o_current_clamp_on_ff});
		chk("speed", 8'h00, {6'h0, o_fine_clamp_speed_ff});
		rdc("analog clamp", 8'h14, 8'h12);
		rdc("digital clamp", 8'h15, 8'h00);
		summarize();
	end
endmodule : tb
